// ---- lfs_host_model.sv ----
// Host model that reads the status words over the read port.
`timescale 1ns/1ps
module lfs_host_model (
  // Clock.
  input  wire logic       mclk,
  // Status read port.
  input  wire logic [7:0] status_rd_data,
  output logic      [7:0] status_rd_addr,
  output logic            status_rd_strobe,
  output logic            status_rd_done
);
  // The port is idle until the first read.
  initial begin
    status_rd_addr   = 8'h5A;
    status_rd_strobe = 1'b0;
    status_rd_done   = 1'b0;
  end

  // One read sequence: strobe, then done, word taken once settled.
  // The address is inverted once taken, so a stale value cannot pass.
  task automatic read_word(input logic [7:0] a, output logic [7:0] w);
    @(negedge mclk);
    status_rd_addr   = a;
    status_rd_strobe = 1'b1;
    @(negedge mclk);
    status_rd_strobe = 1'b0;
    status_rd_done   = 1'b1;
    status_rd_addr   = ~a;
    @(negedge mclk);
    status_rd_done   = 1'b0;
    w                = status_rd_data;
  endtask
endmodule

// ---- lfs_persist.sv ----
// Qualifier that passes a level only after it has stood for a set time.
`timescale 1ns/1ps
module lfs_persist #(
  parameter int CYCLES = lfs_pkg::OCP_DIS_CYCLES
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic nrst,
  // Raw level and qualified result.
  input  wire logic level,
  output logic      qual
);

  localparam int CW = $clog2(CYCLES + 1);
  localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

  typedef struct packed {
    logic [CW-1:0] cnt;  // Cycles the level has stood, saturating.
    logic          q;    // Level has stood longer than the limit.
  } lfs_persist_st_t;

  lfs_persist_st_t st;       // Registered state.
  lfs_persist_st_t next_st;  // Next state.

  // Any gap in the level restarts the count, so short spikes never qualify.
  always_comb begin
    next_st = st;
    if (!level) begin
      next_st.cnt = '0;
      next_st.q   = 1'b0;
    end else if (st.cnt == LIMIT) begin
      next_st.q   = 1'b1;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign qual = st.q;

endmodule

// ---- lfs_pkg.sv ----
// Constants shared by the supply-regulator fault and status logic.
package lfs_pkg;

  // ****************************************************************
  // Status word addresses and bit positions
  // ****************************************************************
  localparam logic [7:0] ADDR_WORD0     = 8'h00;  // Fault status word.
  localparam logic [7:0] ADDR_WORD1     = 8'h01;  // Monitor status word.
  localparam int         W0_OFF_LO      = 0;      // Channel-off flags, bits 1:0.
  localparam int         W0_OC_LO       = 2;      // Overcurrent flags, bits 3:2.
  localparam int         W0_BAD_LO      = 4;      // Output-voltage-bad flags, bits 5:4.
  localparam int         W0_UV          = 6;      // Supply-low flag.
  localparam int         W0_TSD         = 7;      // Thermal trip flag.
  localparam int         W1_PUMP_LO     = 0;      // Pump-good flags, bits 1:0.
  localparam int         W1_TONE_LO     = 2;      // Tone-found flags, bits 3:2.
  localparam int         W1_WARN        = 4;      // Early supply warning.
  localparam int         W1_LOCK        = 5;      // Factory lock flag.
  localparam int         W1_BOOST_LO    = 6;      // Boost-rail-high flags, bits 7:6.

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [1:0] OFF_RESET      = 2'h3;   // Outputs start switched off.
  localparam logic [7:0] RD_DATA_RESET  = 8'h00;

  // ****************************************************************
  // Timing
  // ****************************************************************
  localparam int CLK_PERIOD_NS = 25;              // 40 MHz master clock.
  localparam int TICK_NS       = 500_000;         // Slow timebase, 0.5 ms.
  localparam int TICK_CYCLES   = (TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OCP_DIS_NS    = 1_000_000;       // Overcurrent disable time.
  localparam int OCP_DIS_CYCLES = (OCP_DIS_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int RETRY_NS      = 1_000_000_000;   // Auto-retry period, 1 s.
  localparam int RETRY_CNT_W   = 11;
  localparam logic [RETRY_CNT_W-1:0] RETRY_TICKS = RETRY_CNT_W'(RETRY_NS / TICK_NS);
  localparam int DLY1_NS       = 11_500_000;      // Warning delay code 01.
  localparam int DLY2_NS       = 46_000_000;      // Warning delay code 10.
  localparam int DLY3_NS       = 92_000_000;      // Warning delay code 11.
  localparam int WARN_CNT_W    = 8;
  localparam logic [WARN_CNT_W-1:0] DLY0_TICKS = 8'h00;
  localparam logic [WARN_CNT_W-1:0] DLY1_TICKS = WARN_CNT_W'(DLY1_NS / TICK_NS);
  localparam logic [WARN_CNT_W-1:0] DLY2_TICKS = WARN_CNT_W'(DLY2_NS / TICK_NS);
  localparam logic [WARN_CNT_W-1:0] DLY3_TICKS = WARN_CNT_W'(DLY3_NS / TICK_NS);

endpackage

// ---- lfs_tick.sv ----
// Divider that makes the slow timebase enable pulse.
`timescale 1ns/1ps
module lfs_tick #(
  parameter int TICK_CYCLES = lfs_pkg::TICK_CYCLES
) (
  // Clock and reset.
  input  wire logic mclk,
  input  wire logic nrst,
  // Timebase strobe.
  lfs_tick_if.src   tb
);

  localparam int CW = $clog2(TICK_CYCLES + 1);
  localparam logic [CW-1:0] LAST = CW'(TICK_CYCLES - 1);

  typedef struct packed {
    logic [CW-1:0] cnt;   // Cycles into the current period.
    logic          tick;  // Pulse at the end of a period.
  } lfs_tick_st_t;

  lfs_tick_st_t st;       // Registered state.
  lfs_tick_st_t next_st;  // Next state.

  // The counter wraps at the period end and raises the strobe for one cycle.
  always_comb begin
    next_st = st;
    next_st.tick = (st.cnt == LAST);
    if (st.cnt == LAST) begin
      next_st.cnt = '0;
    end else begin
      next_st.cnt = st.cnt + CW'(1);
    end
  end

  // State register.
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tb.tick = st.tick;

endmodule

// ---- lfs_tick_if.sv ----
// Slow timebase strobe passed from the divider to the status logic.
`timescale 1ns/1ps
interface lfs_tick_if;
  logic tick;  // One-cycle pulse every timebase period.

  modport src (output tick);
  modport dst (input tick);
endinterface

// ---- lfs_top.sv ----
// Fault, status and interrupt logic of the dual-channel supply regulator.
`timescale 1ns/1ps
module lfs_top #(
  parameter int TICK_CYCLES    = lfs_pkg::TICK_CYCLES,
  parameter int OCP_DIS_CYCLES = lfs_pkg::OCP_DIS_CYCLES
) (
  // Clock and reset.
  input  wire logic       mclk,
  input  wire logic       nrst,
  // Control bits held elsewhere in the device.
  input  wire logic [1:0] output_on_bit,
  input  wire logic [1:0] tone_source_bit,
  input  wire logic       restart_policy_bit,
  input  wire logic       warning_delay_sel_lo,
  input  wire logic       warning_delay_sel_hi,
  input  wire logic       factory_lock_flag,
  // Comparator results, synchronous to the clock.
  input  wire logic       supply_low_sense,
  input  wire logic       supply_recovered,
  input  wire logic [1:0] overcurrent_sense,
  input  wire logic       overtemp_sense,
  input  wire logic [1:0] pump_ok_sense,
  input  wire logic [1:0] voltage_outside_wide,
  input  wire logic [1:0] voltage_inside_narrow,
  input  wire logic [1:0] tone_sense_input,
  input  wire logic [1:0] tone_above_receive,
  input  wire logic [1:0] boost_above_set,
  input  wire logic [1:0] boost_below_clear,
  input  wire logic       warning_below,
  input  wire logic       warning_above_hys,
  // Status read port.
  input  wire logic [7:0] status_rd_addr,
  input  wire logic       status_rd_strobe,
  input  wire logic       status_rd_done,
  output logic      [7:0] status_rd_data,
  // Outputs to the power stage and the host.
  output logic      [1:0] channel_enable,
  output logic            irq_n
);

  // ****************************************************************
  // State
  // ****************************************************************
  // One packed state holds every flag, the warning and retry counters and every output register.
  typedef struct packed {
    logic [1:0]                        channel_off_flag;        // Channel switched off.
    logic [1:0]                        overcurrent_flag;        // Latched overcurrent.
    logic [1:0]                        output_voltage_bad_flag; // Output out of window.
    logic                              supply_low_flag;         // Latched undervoltage.
    logic                              thermal_trip_flag;       // Latched overtemperature.
    logic [1:0]                        pump_good_flag;          // Pump voltage adequate.
    logic [1:0]                        tone_found_flag;         // Tone present.
    logic [1:0]                        boost_rail_high_flag;    // Boost rail high.
    logic                              early_supply_warning;    // Early supply warning.
    logic [lfs_pkg::WARN_CNT_W-1:0]    warn_cnt;                // Ticks since recovery.
    logic [lfs_pkg::RETRY_CNT_W-1:0]   retry_cnt;               // Ticks into retry period.
    logic [1:0]                        on_prev;                 // Enable bits last cycle.
    logic                              irq_n;                   // Interrupt line, low active.
    logic [1:0]                        chan_en;                 // Output drive enables.
    logic [7:0]                        rd_data;                 // Captured status word.
  } lfs_state_t;

  lfs_state_t st;       // Registered state.
  lfs_state_t next_st;  // Next state.

  // Signals between the submodules and the next-state logic.
  lfs_tick_if tb ();           // Slow timebase strobe.
  logic [1:0] oc_qualified;    // Overcurrent held past the disable time.
  logic       retry_pulse;     // One-second retry instant.
  logic [lfs_pkg::WARN_CNT_W-1:0] warn_target;  // Selected warning delay in ticks.
  logic [1:0] chan_fault;      // Any fault switching a channel off.
  logic       irq_event;       // A major fault newly appeared.
  logic       irq_cause;       // A major flag is still set.
  logic [7:0] word0;           // Fault status word.
  logic [7:0] word1;           // Monitor status word.

  // ****************************************************************
  // Timebase and overcurrent qualifiers
  // ****************************************************************
  lfs_tick #(
    .TICK_CYCLES (TICK_CYCLES)
  ) u_tick (
    .mclk (mclk),
    .nrst (nrst),
    .tb   (tb)
  );

  // One qualifier per channel filters overcurrent shorter than the disable time.
  // Both channels share one disable time; a per-channel limit would need a port.
  genvar ch;
  generate
    for (ch = 0; ch < 2; ch++) begin : g_oc
      lfs_persist #(
        .CYCLES (OCP_DIS_CYCLES)
      ) u_oc (
        .mclk  (mclk),
        .nrst  (nrst),
        .level (overcurrent_sense[ch]),
        .qual  (oc_qualified[ch])
      );
    end
  endgenerate

  // The retry instant is the tick that closes a full one-second period.
  // The period runs free, so the first retry after a fault may come early.
  assign retry_pulse = tb.tick && (st.retry_cnt == lfs_pkg::RETRY_TICKS - 11'h001);

  // Delay selector for the warning release.
  always_comb begin
    case ({warning_delay_sel_hi, warning_delay_sel_lo})
      2'h0:    warn_target = lfs_pkg::DLY0_TICKS;
      2'h1:    warn_target = lfs_pkg::DLY1_TICKS;
      2'h2:    warn_target = lfs_pkg::DLY2_TICKS;
      2'h3:    warn_target = lfs_pkg::DLY3_TICKS;
      default: warn_target = lfs_pkg::DLY0_TICKS;
    endcase
  end

  // ****************************************************************
  // Next-state logic
  // ****************************************************************
  // Flags that hardware sets take priority over a read clear in the same cycle,
  // so an event landing on the read that would clear it is never lost.
  always_comb begin
    next_st = st;
    chan_fault = 2'h0;
    irq_event = 1'b0;
    irq_cause = 1'b0;

    // Retry period counter, free running on the timebase.
    if (retry_pulse) begin
      next_st.retry_cnt = '0;
    end else if (tb.tick) begin
      next_st.retry_cnt = st.retry_cnt + 11'h001;
    end

    // Undervoltage latches and clears only on a read after recovery.
    if (supply_low_sense) begin
      next_st.supply_low_flag = 1'b1;
    end else if (status_rd_done && supply_recovered) begin
      next_st.supply_low_flag = 1'b0;
    end

    // Thermal trip: read clears in latch mode, retry instant in restart mode.
    if (overtemp_sense) begin
      next_st.thermal_trip_flag = 1'b1;
    end else if (restart_policy_bit ? retry_pulse : status_rd_done) begin
      next_st.thermal_trip_flag = 1'b0;
    end

    // Early warning sets at once; release waits for delay and a read.
    if (warning_below) begin
      next_st.early_supply_warning = 1'b1;
      next_st.warn_cnt = '0;
    end else if (!warning_above_hys) begin
      next_st.warn_cnt = '0;
    end else if (tb.tick && st.warn_cnt < warn_target) begin
      next_st.warn_cnt = st.warn_cnt + 8'h01;
    end
    // A read before the delay ends leaves the flag set; the host reads again.
    if (!warning_below && warning_above_hys && st.warn_cnt >= warn_target
        && status_rd_done) begin
      next_st.early_supply_warning = 1'b0;
    end

    for (int i = 0; i < 2; i++) begin
      // Overcurrent flag, same clearing policy as the thermal flag.
      if (oc_qualified[i]) begin
        next_st.overcurrent_flag[i] = 1'b1;
      end else if (restart_policy_bit ? retry_pulse : status_rd_done) begin
        next_st.overcurrent_flag[i] = 1'b0;
      end

      // Pump and tone monitors track every cycle with no latch; boost-high holds between set and clear.
      next_st.pump_good_flag[i] = pump_ok_sense[i];
      next_st.tone_found_flag[i] = tone_source_bit[i] ? tone_sense_input[i]
                                                      : tone_above_receive[i];
      if (boost_above_set[i]) begin
        next_st.boost_rail_high_flag[i] = 1'b1;
      end else if (boost_below_clear[i]) begin
        next_st.boost_rail_high_flag[i] = 1'b0;
      end

      // Channel-off: any fault or a low enable forces it; release needs a fresh
      // enable or, in restart mode, a retry instant with every fault gone.
      chan_fault[i] = next_st.supply_low_flag || next_st.thermal_trip_flag
                      || next_st.overcurrent_flag[i] || !pump_ok_sense[i];
      if (!output_on_bit[i] || chan_fault[i]) begin
        next_st.channel_off_flag[i] = 1'b1;
      end else if ((output_on_bit[i] && !st.on_prev[i])
                   || (restart_policy_bit && retry_pulse)) begin
        next_st.channel_off_flag[i] = 1'b0;
      end
      // Remember the enable bit, so only a fresh turn-on, or a retry in restart mode, releases the channel.
      next_st.on_prev[i] = output_on_bit[i];
      next_st.chan_en[i] = !next_st.channel_off_flag[i];

      // Voltage window only judged while the channel drives.
      if (!next_st.chan_en[i]) begin
        next_st.output_voltage_bad_flag[i] = 1'b0;
      end else if (voltage_outside_wide[i]) begin
        next_st.output_voltage_bad_flag[i] = 1'b1;
      end else if (voltage_inside_narrow[i]) begin
        next_st.output_voltage_bad_flag[i] = 1'b0;
      end
    end

    // Interrupt: new major fault pulls low; a read releases unless a cause
    // remains. Channel-off, voltage-bad and boost flags never take part.
    irq_event = (|(next_st.overcurrent_flag & ~st.overcurrent_flag))
                || (next_st.supply_low_flag && !st.supply_low_flag)
                || (next_st.thermal_trip_flag && !st.thermal_trip_flag)
                || (next_st.early_supply_warning && !st.early_supply_warning);
    irq_cause = (|next_st.overcurrent_flag) || next_st.supply_low_flag
                || next_st.thermal_trip_flag || next_st.early_supply_warning;
    // Set beats the read, so a fault arriving with the read is not lost.
    if (irq_event) begin
      next_st.irq_n = 1'b0;
    end else if (status_rd_done) begin
      next_st.irq_n = !irq_cause;
    end

    // Status words captured on the read strobe; unknown addresses read zero.
    word0 = {st.thermal_trip_flag, st.supply_low_flag, st.output_voltage_bad_flag,
             st.overcurrent_flag, st.channel_off_flag};
    word1 = {st.boost_rail_high_flag, factory_lock_flag, st.early_supply_warning,
             st.tone_found_flag, st.pump_good_flag};
    if (status_rd_strobe) begin
      case (status_rd_addr)
        lfs_pkg::ADDR_WORD0: next_st.rd_data = word0;
        lfs_pkg::ADDR_WORD1: next_st.rd_data = word1;
        default:             next_st.rd_data = lfs_pkg::RD_DATA_RESET;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st <= '0;
      // Only constants here: outputs off, interrupt line released.
      st.channel_off_flag <= lfs_pkg::OFF_RESET;
      st.irq_n <= 1'b1;
    end else begin
      st <= next_st;
    end
  end

  // Every output is a register bit, so nothing combinational reaches a pin.
  assign status_rd_data = st.rd_data;
  assign channel_enable = st.chan_en;
  assign irq_n = st.irq_n;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // All checks use the master clock and rest while reset is held.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!nrst);

  // Undervoltage stops both outputs and pulls the interrupt.
  chk_uv_stops_all: assert property (supply_low_sense |=>
    st.supply_low_flag && st.channel_off_flag == 2'h3 && !irq_n && channel_enable == 2'h0)
    else $error("undervoltage did not stop outputs and interrupt");

  // The supply-low flag survives anything but a qualified read.
  chk_uv_read_clear: assert property (st.supply_low_flag && !(status_rd_done
    && supply_recovered) |=> st.supply_low_flag)
    else $error("undervoltage flag cleared without qualified read");

  // A pump fault on the second channel switches that channel off.
  chk_pump_off_chan: assert property (!pump_ok_sense[1] |=>
    st.channel_off_flag[1] && !channel_enable[1] && !st.pump_good_flag[1])
    else $error("pump fault did not switch channel off");

  // Overtemperature switches both channels off.
  chk_thermal_both_off: assert property (overtemp_sense |=>
    st.thermal_trip_flag && st.channel_off_flag == 2'h3)
    else $error("overtemperature did not switch outputs off");

  // Overcurrent clears only on the clear event of the active policy.
  chk_oc_clear_cause: assert property ($fell(st.overcurrent_flag[0]) |->
    ($past(restart_policy_bit) ? $past(retry_pulse) : $past(status_rd_done)))
    else $error("overcurrent flag cleared at wrong moment");

  // Latched overcurrent always holds its channel off.
  chk_oc_holds_off: assert property (st.overcurrent_flag[0] |->
    st.channel_off_flag[0] && !channel_enable[0])
    else $error("overcurrent left channel driving");

  // Only a read may release the interrupt line.
  chk_irq_release_read: assert property ($rose(irq_n) |-> $past(status_rd_done))
    else $error("interrupt released without a read");

  // Only a major flag may pull the interrupt line low.
  chk_irq_major_only: assert property ($fell(irq_n) |-> (|st.overcurrent_flag)
    || st.supply_low_flag || st.thermal_trip_flag || st.early_supply_warning)
    else $error("interrupt pulled low without a major fault");

  // The warning sets its flag and the interrupt at once.
  chk_warn_pulls_irq: assert property (warning_below |=> st.early_supply_warning && !irq_n)
    else $error("warning did not set flag and interrupt");

  // The tone flag follows the threshold picked by its source bit.
  chk_tone_threshold: assert property (##1 st.tone_found_flag[1] ==
    ($past(tone_source_bit[1]) ? $past(tone_sense_input[1]) : $past(tone_above_receive[1])))
    else $error("tone flag used wrong threshold");

  // Boost-high sets on its comparator and leaves the interrupt alone.
  chk_boost_no_irq: assert property (boost_above_set[0] && irq_n && !irq_event
    |=> st.boost_rail_high_flag[0] && irq_n)
    else $error("boost flag wrong or disturbed interrupt");

  // Voltage-bad is never shown for a channel that does not drive.
  chk_bad_needs_enable: assert property (!channel_enable[1] |->
    !st.output_voltage_bad_flag[1])
    else $error("voltage-bad set on disabled channel");

  // A channel comes back only with its enable bit high and no shared fault.
  chk_off_needs_on: assert property ($fell(st.channel_off_flag[0]) |->
    $past(output_on_bit[0]) && !st.supply_low_flag && !st.thermal_trip_flag)
    else $error("channel came back without enable or with a fault");

endmodule

// ---- testbench.sv ----
// Self-checking bench for the fault, status and interrupt logic.
`timescale 1ns/1ps
module testbench;
  // ****************************************************************
  // Signals and instances
  // ****************************************************************
  localparam int TK = 4;  // Shortened timebase, cycles per tick.
  localparam int OD = 8;  // Shortened overcurrent disable time.
  logic mclk, nrst, restart_policy_bit, warning_delay_sel_lo, warning_delay_sel_hi;
  logic factory_lock_flag, supply_low_sense, supply_recovered, overtemp_sense;
  logic warning_below, warning_above_hys, status_rd_strobe, status_rd_done, irq_n;
  logic [1:0] output_on_bit, tone_source_bit, overcurrent_sense, pump_ok_sense;
  logic [1:0] voltage_outside_wide, voltage_inside_narrow, tone_sense_input;
  logic [1:0] tone_above_receive, boost_above_set, boost_below_clear, channel_enable;
  logic [1:0] bst, vb;             // Expected boost-high and voltage-bad flags.
  logic [7:0] status_rd_addr, status_rd_data, d;
  logic [31:0] seed = 32'h0000001E; // Fixed seed keeps runs repeatable.
  int num_errors = 0;
  int comparisons = 0;

  lfs_top #(.TICK_CYCLES(TK), .OCP_DIS_CYCLES(OD)) i_lfs_top (.mclk, .nrst,
    .output_on_bit, .tone_source_bit, .restart_policy_bit, .warning_delay_sel_lo,
    .warning_delay_sel_hi, .factory_lock_flag, .supply_low_sense, .supply_recovered,
    .overcurrent_sense, .overtemp_sense, .pump_ok_sense, .voltage_outside_wide,
    .voltage_inside_narrow, .tone_sense_input, .tone_above_receive, .boost_above_set,
    .boost_below_clear, .warning_below, .warning_above_hys, .status_rd_addr,
    .status_rd_strobe, .status_rd_done, .status_rd_data, .channel_enable, .irq_n);
  lfs_host_model i_lfs_host_model (.mclk, .status_rd_data, .status_rd_addr,
    .status_rd_strobe, .status_rd_done);

  // ****************************************************************
  // Helpers
  // ****************************************************************
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Expected status word zero from its flags.
  function automatic logic [7:0] w0(logic th, logic uv, logic [1:0] v, logic [1:0] oc,
                                    logic [1:0] off);
    return {th, uv, v, oc, off};
  endfunction
  // Warning release delay in cycles: milliseconds over a 0.5 ms tick.
  function automatic int dly(int c);
    return (c == 1) ? 23 * TK : (c == 2) ? 92 * TK : (c == 3) ? 184 * TK : 0;
  endfunction
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      num_errors++;
      $display("FAIL %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge mclk);
  endtask
  task automatic rd(input logic [7:0] a);
    i_lfs_host_model.read_word(a, d);
  endtask
  // Channels come back only on a fresh rising enable bit, or on a retry in restart mode.
  task automatic reon();
    output_on_bit = 2'h0;
    cyc(2);
    output_on_bit = 2'h3;
    cyc(2);
  endtask
  task automatic test_done();
    $display("errors %0d comparisons %0d", num_errors, comparisons);
    if (num_errors == 0 && comparisons > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  initial begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end
  // Watchdog: the sequence needs about 10200 cycles.
  initial begin
    repeat (40000) @(posedge mclk);
    num_errors++;
    test_done();
  end

  // ****************************************************************
  // Main sequence
  // ****************************************************************
  initial begin
    {nrst, restart_policy_bit, warning_delay_sel_hi, warning_delay_sel_lo} = 4'h0;
    {factory_lock_flag, supply_low_sense, overtemp_sense, warning_below} = 4'h0;
    {supply_recovered, warning_above_hys, bst, vb} = 6'h30;
    {output_on_bit, tone_source_bit, overcurrent_sense, tone_sense_input} = 8'h00;
    {tone_above_receive, boost_above_set, voltage_outside_wide} = 6'h00;
    {pump_ok_sense, voltage_inside_narrow, boost_below_clear} = 6'h3F;
    cyc(16);
    nrst = 1'b1;
    rd(8'h00);
    chk("word0", 8'h03, d);
    reon();
    chk("enable", 8'h03, 8'(channel_enable));
    // Supply low: latched, held while the supply is still down.
    supply_low_sense = 1'b1;
    supply_recovered = 1'b0;
    cyc(2);
    supply_low_sense = 1'b0;
    chk("irq", 8'h00, 8'(irq_n));
    chk("enable", 8'h00, 8'(channel_enable));
    rd(8'h00);
    rd(8'h00);
    chk("word0", w0(0, 1, 0, 0, 3), d);
    chk("irq", 8'h00, 8'(irq_n));
    supply_recovered = 1'b1;
    rd(8'h00);
    rd(8'h00);
    chk("word0", 8'h03, d);
    chk("irq", 8'h01, 8'(irq_n));
    reon();
    // Overcurrent on channel 1, latch mode.
    overcurrent_sense = 2'h1;
    cyc(OD - 2);
    chk("enable", 8'h03, 8'(channel_enable));
    cyc(6);
    chk("enable", 8'h02, 8'(channel_enable));
    rd(8'h00);
    rd(8'h00);
    chk("word0", w0(0, 0, 0, 1, 1), d);
    overcurrent_sense = 2'h0;
    rd(8'h00);
    rd(8'h00);
    chk("word0", w0(0, 0, 0, 0, 1), d);
    reon();
    // Overtemperature switches both outputs off.
    overtemp_sense = 1'b1;
    cyc(2);
    overtemp_sense = 1'b0;
    rd(8'h00);
    chk("word0", w0(1, 0, 0, 0, 3), d);
    chk("irq", 8'h01, 8'(irq_n));
    reon();
    // Pump fault on channel 2 only; pump flag itself does not latch.
    pump_ok_sense = 2'h1;
    cyc(2);
    chk("enable", 8'h01, 8'(channel_enable));
    pump_ok_sense = 2'h3;
    rd(8'h01);
    chk("pump", 8'h03, 8'(d[1:0]));
    rd(8'h02);
    chk("word2", 8'h00, d);
    reon();
    // Random tracking flags; irq must stay released throughout.
    repeat (24) begin
      d = 8'(xs());
      {tone_source_bit, tone_sense_input, tone_above_receive, factory_lock_flag} = 7'(xs());
      boost_above_set = d[1:0];
      boost_below_clear = ~d[1:0] & d[3:2];
      voltage_outside_wide = d[5:4];
      voltage_inside_narrow = ~d[5:4] & d[7:6];
      bst = (bst | boost_above_set) & ~boost_below_clear;
      vb = (vb | voltage_outside_wide) & ~voltage_inside_narrow;
      cyc(2);
      rd(8'h01);
      chk("word1", {bst, factory_lock_flag, 1'b0, (tone_source_bit & tone_sense_input) |
          (~tone_source_bit & tone_above_receive), 2'h3}, d);
      rd(8'h00);
      chk("word0", w0(0, 0, vb, 0, 0), d);
      chk("irq", 8'h01, 8'(irq_n));
    end
    voltage_outside_wide = 2'h0;
    voltage_inside_narrow = 2'h3;
    // Warning release delay for every code.
    for (int c = 0; c < 4; c++) begin
      {warning_delay_sel_hi, warning_delay_sel_lo} = 2'(c);
      {warning_below, warning_above_hys} = 2'h2;
      cyc(2);
      chk("irq", 8'h00, 8'(irq_n));
      {warning_below, warning_above_hys} = 2'h1;
      if (c > 0) begin
        cyc(dly(c) / 2);
        rd(8'h01);
        rd(8'h01);
        chk("warn", 8'h01, 8'(d[4]));
      end
      cyc(dly(c) + 2 * TK);
      rd(8'h01);
      rd(8'h01);
      chk("warn", 8'h00, 8'(d[4]));
    end
    // Restart mode: a read does not clear, the one-second retry does.
    restart_policy_bit = 1'b1;
    overtemp_sense = 1'b1;
    cyc(2);
    overtemp_sense = 1'b0;
    rd(8'h00);
    rd(8'h00);
    chk("thermal", 8'h01, 8'(d[7]));
    cyc(2000 * TK + 4 * TK);
    chk("enable", 8'h03, 8'(channel_enable));
    rd(8'h00);
    chk("word0", 8'h00, d);
    chk("irq", 8'h01, 8'(irq_n));
    test_done();
  end
endmodule
